// ---- logic/cmpev_pkg.sv ----
// Package: register map, field positions and state types of the comparator event block
package cmpev_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int CMPEV_NUNIT  = 3;
    localparam int CMPEV_ADDR_W = 8;
    localparam int CMPEV_DATA_W = 16;
    localparam int CMPEV_SRC_W  = 4;

    // ****************************************************************
    // Register offsets (byte addresses, four bytes apart)
    // ****************************************************************
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_CON_BASE = 8'h04;
    localparam logic [7:0] OFS_MSK_BASE = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_STRIDE   = 8'h04;

    // ****************************************************************
    // Shared status register fields
    // ****************************************************************
    localparam int ST_HALT    = 15;
    localparam int ST_EVT_LSB = 8;
    localparam int ST_RES_LSB = 0;

    // ****************************************************************
    // Per-unit control register fields
    // ****************************************************************
    localparam int CON_EN       = 15;
    localparam int CON_PIN      = 14;
    localparam int CON_INV      = 13;
    localparam int CON_EVT      = 9;
    localparam int CON_RES      = 8;
    localparam int CON_EDGE_LSB = 6;
    localparam int CON_POS      = 4;
    localparam int CON_NEG_LSB  = 0;

    // ****************************************************************
    // Blanking source register fields
    // ****************************************************************
    localparam int MSK_A_LSB = 0;
    localparam int MSK_B_LSB = 4;
    localparam int MSK_C_LSB = 8;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY  = 2'b11
    } cmpev_edge_e;

    // Negative input routing codes driven to the analog mux
    localparam logic [1:0] NEG_EXT_B    = 2'h0;
    localparam logic [1:0] NEG_EXT_C    = 2'h1;
    localparam logic [1:0] NEG_EXT_D    = 2'h2;
    localparam logic [1:0] NEG_BANDGAP  = 2'h3;
    // Positive input routing codes
    localparam logic       POS_EXT_A    = 1'h0;
    localparam logic       POS_LADDER   = 1'h1;

    // ****************************************************************
    // State types
    // ****************************************************************
    typedef struct packed {
        logic s1;
        logic s2;
        logic res;
        logic prev;
    } cmpev_unit_s;

    typedef struct packed {
        logic                                    halt;
        logic [CMPEV_NUNIT-1:0]                  en;
        logic [CMPEV_NUNIT-1:0]                  pin_en;
        logic [CMPEV_NUNIT-1:0]                  inv;
        logic [CMPEV_NUNIT-1:0][1:0]             edge_sel;
        logic [CMPEV_NUNIT-1:0]                  pos_sel;
        logic [CMPEV_NUNIT-1:0][1:0]             neg_sel;
        logic [CMPEV_NUNIT-1:0][CMPEV_SRC_W-1:0] blank_a;
        logic [CMPEV_NUNIT-1:0][CMPEV_SRC_W-1:0] blank_b;
        logic [CMPEV_NUNIT-1:0][CMPEV_SRC_W-1:0] blank_c;
        logic [CMPEV_NUNIT-1:0]                  evt;
        logic [CMPEV_NUNIT-1:0]                  irq_stat;
        logic [CMPEV_NUNIT-1:0]                  irq_mask;
        logic [CMPEV_NUNIT-1:0]                  pwr;
        logic [CMPEV_NUNIT-1:0]                  trig;
        logic [CMPEV_NUNIT-1:0]                  pin_out;
        logic [CMPEV_NUNIT-1:0]                  pin_oe;
        logic                                    irq;
        logic [CMPEV_DATA_W-1:0]                 rdata;
    } cmpev_state_s;

    localparam cmpev_state_s CMPEV_STATE_RST = '0;
    localparam cmpev_unit_s  CMPEV_UNIT_RST  = '0;

endpackage

// ---- logic/cmpev_top.sv ----
// Module: register bank and event control of three comparators
//
// Operation
// - Halt bit stops all comparators in idle
// - Shared status mirrors event flags and results
// - Three identical comparator units with own control
// - Control bit 15 enables; another drives pin
// - Result bit follows inputs, inverted by polarity
// - Matching edge sets event flag, blocks further triggers
// - Edge select 11 fires on any change
// - Edge select 10 fires on adjusted falling edge
// - Positive input: ladder reference or external A
// - Negative input: external B, C, D or bandgap
// - Unimplemented bits ignore writes, read zero
// - Three 4-bit blanking source selects per unit
`timescale 1ns/1ns
`default_nettype none
module cmpev_top
    import cmpev_pkg::*;
#(
    parameter int NUNIT = CMPEV_NUNIT
)
(
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            reset_n,
    // Register port
    input  wire logic [CMPEV_ADDR_W-1:0]         reg_addr,
    input  wire logic [CMPEV_DATA_W-1:0]         reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [CMPEV_DATA_W-1:0]         reg_rdata,
    // System
    input  wire logic                            idle_mode,
    // Analog comparator results and controls
    input  wire logic [NUNIT-1:0]                cmp_raw,
    output logic      [NUNIT-1:0]                unit_power_on,
    output logic      [NUNIT-1:0]                positive_input_select,
    output logic      [NUNIT-1:0][1:0]           negative_input_select,
    // Blanking source selects
    output logic      [NUNIT-1:0][CMPEV_SRC_W-1:0] blank_a_source,
    output logic      [NUNIT-1:0][CMPEV_SRC_W-1:0] blank_b_source,
    output logic      [NUNIT-1:0][CMPEV_SRC_W-1:0] blank_c_source,
    // Result pins
    output logic      [NUNIT-1:0]                result_pin_out,
    output logic      [NUNIT-1:0]                result_pin_oe,
    // Events
    output logic      [NUNIT-1:0]                event_trigger,
    output logic                                 irq
);

    cmpev_state_s            st_ff;
    cmpev_state_s            nxt_st;
    logic        [NUNIT-1:0] unit_res;
    logic        [NUNIT-1:0] unit_hit;
    logic        [NUNIT-1:0] unit_active;

    // ****************************************************************
    // Comparator units
    // ****************************************************************
    // Units only take power and detect edges while enabled and not halted by idle; the result keeps following the input
    for (genvar g = 0; g < NUNIT; g++)
    begin : g_unit
        cmpev_unit_if uif ();

        assign unit_active[g] = st_ff.en[g]
                              & ~(idle_mode & st_ff.halt);
        assign uif.active     = unit_active[g];
        assign uif.invert     = st_ff.inv[g];
        assign uif.edge_sel   = st_ff.edge_sel[g];
        assign unit_res[g]    = uif.result;
        assign unit_hit[g]    = uif.hit;

        cmpev_unit u_unit (
            .core_clk (core_clk),
            .reset_n  (reset_n),
            .raw_in   (cmp_raw[g]),
            .u        (uif.unit)
        );
    end

    // ****************************************************************
    // Address helpers
    // ****************************************************************
    function automatic logic [CMPEV_ADDR_W-1:0] con_addr(input int i);
        con_addr = CMPEV_ADDR_W'(OFS_CON_BASE + OFS_STRIDE * i);
    endfunction

    function automatic logic [CMPEV_ADDR_W-1:0] msk_addr(input int i);
        msk_addr = CMPEV_ADDR_W'(OFS_MSK_BASE + OFS_STRIDE * i);
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [CMPEV_DATA_W-1:0] rd;
        logic                    fire;
        rd          = '0;
        fire        = 1'b0;
        nxt_st      = st_ff;
        nxt_st.trig = '0;
        nxt_st.rdata = '0;

        // Shared status: only the halt bit is writable
        if (reg_wr && reg_addr == OFS_STATUS)
            nxt_st.halt = reg_wdata[ST_HALT];

        // Interrupt status is write-one-to-clear; set wins below
        if (reg_wr && reg_addr == OFS_IRQ_STAT)
            nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata[NUNIT-1:0];
        if (reg_wr && reg_addr == OFS_IRQ_MASK)
            nxt_st.irq_mask = reg_wdata[NUNIT-1:0];

        for (int i = 0; i < NUNIT; i++)
        begin
            if (reg_wr && reg_addr == con_addr(i))
            begin
                nxt_st.en[i]       = reg_wdata[CON_EN];
                nxt_st.pin_en[i]   = reg_wdata[CON_PIN];
                nxt_st.inv[i]      = reg_wdata[CON_INV];
                nxt_st.edge_sel[i] = reg_wdata[CON_EDGE_LSB +: 2];
                nxt_st.pos_sel[i]  = reg_wdata[CON_POS];
                nxt_st.neg_sel[i]  = reg_wdata[CON_NEG_LSB +: 2];
                // Writing 1 to the event bit leaves it as it is
                if (!reg_wdata[CON_EVT])
                    nxt_st.evt[i] = 1'b0;
            end

            if (reg_wr && reg_addr == msk_addr(i))
            begin
                nxt_st.blank_a[i] = reg_wdata[MSK_A_LSB +: CMPEV_SRC_W];
                nxt_st.blank_b[i] = reg_wdata[MSK_B_LSB +: CMPEV_SRC_W];
                nxt_st.blank_c[i] = reg_wdata[MSK_C_LSB +: CMPEV_SRC_W];
            end

            // A pending event masks further triggers and interrupts
            fire = unit_hit[i] & ~st_ff.evt[i];
            if (fire)
            begin
                nxt_st.evt[i]      = 1'b1;
                nxt_st.trig[i]     = 1'b1;
                nxt_st.irq_stat[i] = 1'b1;
            end

            nxt_st.pwr[i]     = unit_active[i];
            nxt_st.pin_out[i] = unit_res[i];
            nxt_st.pin_oe[i]  = st_ff.pin_en[i] & st_ff.en[i];
        end

        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

        // Read mux: data stand only in the cycle after the strobe
        if (reg_rd)
        begin
            if (reg_addr == OFS_STATUS)
            begin
                rd[ST_HALT]                 = st_ff.halt;
                rd[ST_EVT_LSB +: NUNIT]     = st_ff.evt;
                rd[ST_RES_LSB +: NUNIT]     = unit_res;
            end
            if (reg_addr == OFS_IRQ_STAT)
                rd[NUNIT-1:0] = st_ff.irq_stat;
            if (reg_addr == OFS_IRQ_MASK)
                rd[NUNIT-1:0] = st_ff.irq_mask;
            for (int i = 0; i < NUNIT; i++)
            begin
                if (reg_addr == con_addr(i))
                begin
                    rd[CON_EN]               = st_ff.en[i];
                    rd[CON_PIN]              = st_ff.pin_en[i];
                    rd[CON_INV]              = st_ff.inv[i];
                    rd[CON_EVT]              = st_ff.evt[i];
                    rd[CON_RES]              = unit_res[i];
                    rd[CON_EDGE_LSB +: 2]    = st_ff.edge_sel[i];
                    rd[CON_POS]              = st_ff.pos_sel[i];
                    rd[CON_NEG_LSB +: 2]     = st_ff.neg_sel[i];
                end
                if (reg_addr == msk_addr(i))
                begin
                    rd[MSK_A_LSB +: CMPEV_SRC_W] = st_ff.blank_a[i];
                    rd[MSK_B_LSB +: CMPEV_SRC_W] = st_ff.blank_b[i];
                    rd[MSK_C_LSB +: CMPEV_SRC_W] = st_ff.blank_c[i];
                end
            end
        end
        // Bits not assigned above stay zero
        nxt_st.rdata = rd;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= CMPEV_STATE_RST;
        else
            st_ff <= nxt_st;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata             = st_ff.rdata;
    assign unit_power_on         = st_ff.pwr;
    assign positive_input_select = st_ff.pos_sel;
    assign negative_input_select = st_ff.neg_sel;
    assign blank_a_source        = st_ff.blank_a;
    assign blank_b_source        = st_ff.blank_b;
    assign blank_c_source        = st_ff.blank_c;
    assign result_pin_out        = st_ff.pin_out;
    assign result_pin_oe         = st_ff.pin_oe;
    assign event_trigger         = st_ff.trig;
    assign irq                   = st_ff.irq;

endmodule // cmpev_top
`default_nettype wire

// ---- logic/cmpev_unit.sv ----
// Module: synchroniser, polarity and edge detection for one comparator
`timescale 1ns/1ns
`default_nettype none
module cmpev_unit
    import cmpev_pkg::*;
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   reset_n,
    // Raw analog comparator result
    input  wire logic   raw_in,
    // Control side
    cmpev_unit_if.unit  u
);

    cmpev_unit_s st_ff;
    cmpev_unit_s nxt_st;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.s1   = raw_in;
        nxt_st.s2   = st_ff.s1;
        nxt_st.res  = st_ff.s2 ^ u.invert;
        nxt_st.prev = st_ff.res;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_ff <= CMPEV_UNIT_RST;
        else
            st_ff <= nxt_st;
    end

    // ****************************************************************
    // Edge match on the polarity-adjusted result
    // ****************************************************************
    // Flipping the polarity bit looks like a result change and may fire
    always_comb
    begin
        unique case (cmpev_edge_e'(u.edge_sel))
            EDGE_OFF:  u.hit = 1'b0;
            EDGE_RISE: u.hit = u.active & st_ff.res & ~st_ff.prev;
            EDGE_FALL: u.hit = u.active & ~st_ff.res & st_ff.prev;
            EDGE_ANY:  u.hit = u.active & (st_ff.res ^ st_ff.prev);
        endcase
    end

    assign u.result = st_ff.res;

endmodule // cmpev_unit
`default_nettype wire

// ---- logic/cmpev_unit_if.sv ----
// Interface: configuration and result signals between control and one unit
`timescale 1ns/1ns
`default_nettype none
interface cmpev_unit_if;
    logic       active;
    logic       invert;
    logic [1:0] edge_sel;
    logic       result;
    logic       hit;

    modport unit (input active, input invert, input edge_sel,
                  output result, output hit);
    modport ctrl (output active, output invert, output edge_sel,
                  input result, input hit);
endinterface
`default_nettype wire

// ---- tb/cmpev_top_asserts.sv ----
// Checker: port-level assertions of the comparator event block
`timescale 1ns/1ns
`default_nettype none
module cmpev_top_asserts
    import cmpev_pkg::*;
#(
    parameter int NUNIT = CMPEV_NUNIT
)
(
    // Clock and reset
    input wire logic                              core_clk,
    input wire logic                              reset_n,
    // Register port
    input wire logic [CMPEV_ADDR_W-1:0]           reg_addr,
    input wire logic [CMPEV_DATA_W-1:0]           reg_wdata,
    input wire logic                              reg_wr,
    input wire logic                              reg_rd,
    input wire logic [CMPEV_DATA_W-1:0]           reg_rdata,
    // System and outputs
    input wire logic                              idle_mode,
    input wire logic [NUNIT-1:0]                  unit_power_on,
    input wire logic [NUNIT-1:0]                  positive_input_select,
    input wire logic [NUNIT-1:0][1:0]             negative_input_select,
    input wire logic [NUNIT-1:0][CMPEV_SRC_W-1:0] blank_a_source,
    input wire logic [NUNIT-1:0]                  result_pin_oe,
    input wire logic [NUNIT-1:0]                  event_trigger,
    input wire logic                              irq
);
    // ****************************************************************
    // Shadow of the halt, enable, pin enable and interrupt mask bits
    // ****************************************************************
    logic             halt_ff;
    logic [NUNIT-1:0] en_ff;
    logic [NUNIT-1:0] pin_ff;
    logic [NUNIT-1:0] msk_ff;
    logic [NUNIT-1:0] exp_pw;
    logic [NUNIT-1:0] exp_oe;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            halt_ff <= 1'b0;
            en_ff   <= '0;
            pin_ff  <= '0;
            msk_ff  <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == OFS_STATUS)
                halt_ff <= reg_wdata[ST_HALT];
            if (reg_addr == OFS_IRQ_MASK)
                msk_ff <= reg_wdata[NUNIT-1:0];
            for (int i = 0; i < NUNIT; i++)
            begin
                if (reg_addr == OFS_CON_BASE + OFS_STRIDE * 8'(i))
                begin
                    en_ff[i]  <= reg_wdata[CON_EN];
                    pin_ff[i] <= reg_wdata[CON_PIN];
                end
            end
        end
    end

    assign exp_pw = en_ff & ~{NUNIT{idle_mode & halt_ff}};
    assign exp_oe = en_ff & pin_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_rdata_quiet: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read cycle");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr > OFS_IRQ_MASK |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    chk_status_ro: assert property (
        reg_rd && reg_addr == OFS_STATUS |=> reg_rdata[ST_HALT] == halt_ff
        && reg_rdata[14:11] == '0 && reg_rdata[7:3] == '0)
        else $error("status register layout wrong");
    chk_power_idle: assert property (
        $stable(exp_pw) && $past($stable(exp_pw)) |-> unit_power_on == exp_pw)
        else $error("unit power does not follow enable and halt");
    chk_pin_enable: assert property (
        $stable(exp_oe) && $past($stable(exp_oe)) |-> result_pin_oe == exp_oe)
        else $error("pin enable does not follow control");
    chk_blank_load: assert property (
        reg_wr && reg_addr == OFS_MSK_BASE
        |=> blank_a_source[0] == $past(reg_wdata[3:0]))
        else $error("blank source not loaded");
    chk_input_sel: assert property (
        reg_wr && reg_addr == OFS_CON_BASE + 8'h08
        |=> negative_input_select[2] == $past(reg_wdata[1:0])
        && positive_input_select[2] == $past(reg_wdata[CON_POS]))
        else $error("input select not loaded");
    chk_trig_pulse: assert property (
        (event_trigger & $past(event_trigger)) == '0)
        else $error("trigger longer than one cycle");
    chk_trig_enabled: assert property (
        (event_trigger & ~$past(en_ff) & ~$past(en_ff, 2)) == '0)
        else $error("trigger from disabled unit");
    chk_irq_follow: assert property (
        (event_trigger & msk_ff) != '0 && $stable(msk_ff) |-> irq)
        else $error("unmasked event without interrupt");
    chk_irq_masked: assert property (
        msk_ff == '0 && $past(msk_ff) == '0 |-> !irq)
        else $error("interrupt while fully masked");

    cover property (event_trigger[0]);
    cover property (irq ##1 !irq);
    cover property (idle_mode && halt_ff && en_ff != '0);
endmodule // cmpev_top_asserts

bind cmpev_top cmpev_top_asserts #(.NUNIT(NUNIT)) i_cmpev_top_asserts (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .idle_mode(idle_mode),
    .unit_power_on(unit_power_on),
    .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select),
    .blank_a_source(blank_a_source), .result_pin_oe(result_pin_oe),
    .event_trigger(event_trigger), .irq(irq));
`default_nettype wire

// ---- tb/cmpev_top_tb.sv ----
// Testbench: self-checking random and corner tests of the comparator block
`timescale 1ns/1ns
`default_nettype none
module cmpev_top_tb
    import cmpev_pkg::*;
;
    logic              core_clk, reset_n, reg_wr, reg_rd, idle_mode, irq;
    logic [7:0]        reg_addr;
    logic [15:0]       reg_wdata, reg_rdata;
    logic [2:0]        cmp_raw, unit_power_on, pos_sel, pin_out, pin_oe, trig;
    logic [2:0][1:0]   neg_sel;
    logic [2:0][3:0]   blk_a, blk_b, blk_c;
    int                num_errors = 0;
    int                checked    = 0;
    int                trig_cnt   = 0;

    cmpev_top i_cmpev_top (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
        .cmp_raw(cmp_raw), .unit_power_on(unit_power_on),
        .positive_input_select(pos_sel), .negative_input_select(neg_sel),
        .blank_a_source(blk_a), .blank_b_source(blk_b),
        .blank_c_source(blk_c), .result_pin_out(pin_out),
        .result_pin_oe(pin_oe), .event_trigger(trig), .irq(irq));

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) trig_cnt <= trig_cnt + $countones(trig);

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic fires(input logic [1:0] e, input logic inv,
                                   input logic rise);
        fires = e == 2'b11 || (e == 2'b01 && (rise ^ inv))
                || (e == 2'b10 && !(rise ^ inv));
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #2000000;
        num_errors++;
        print_verdict;
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        logic [15:0] d, cfg;
        logic [1:0]  e;
        logic        inv, clr, f1, f2, ev;
        int          base, n;
        logic [7:0]  a;
        core_clk = 1'b0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 16'h0000; idle_mode = 1'b0;
        cmp_raw = 3'h0;
        void'($urandom(15));
        idle(2);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++)
            rchk(8'(4 * i), 16'h0000);
        chk(16'({unit_power_on, pin_oe, trig, irq}), 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            for (int r = 0; r < 4; r++)
            begin
                d = 16'($urandom) & 16'he013;
                a = OFS_CON_BASE + 8'(4 * i);
                // Ones in every unimplemented and read-only position
                wr(a, d | 16'h1f2c);
                idle(3);
                rchk(a, d | {7'h0, d[13], 8'h0});
                chk(16'({pos_sel[i], neg_sel[i], pin_oe[i], unit_power_on[i],
                    pin_out[i]}), 16'({d[4], d[1:0], d[15] & d[14], d[15],
                    d[13]}));
                d = (r == 0) ? 16'hff50 : 16'($urandom);
                a = OFS_MSK_BASE + 8'(4 * i);
                wr(a, d);
                rchk(a, d & 16'h0fff);
                chk(16'({blk_c[i], blk_b[i], blk_a[i]}), d & 16'h0fff);
            end
            wr(OFS_CON_BASE + 8'(4 * i), 16'h0000);
        end
        wr(8'h24, 16'hffff);
        rchk(8'h24, 16'h0000);
        $display("test registers done");
        wr(OFS_IRQ_MASK, 16'h0007);
        for (int k = 0; k < 9; k++)
        begin
            e   = (k == 8) ? 2'b11 : 2'(k);
            inv = k[2];
            clr = (k < 8);
            f1  = fires(e, inv, 1'b1);
            f2  = fires(e, inv, 1'b0);
            cfg = {2'b10, inv, 13'h0};
            wr(OFS_CON_BASE, cfg);
            idle(6);
            cfg = cfg | {8'h0, e, 6'h0};
            wr(OFS_CON_BASE, cfg);
            wr(OFS_IRQ_STAT, 16'h0007);
            base = trig_cnt;
            cmp_raw <= 3'b001;
            idle(8);
            rchk(OFS_STATUS, {7'h0, f1, 7'h0, ~inv});
            if (clr)
                wr(OFS_CON_BASE, cfg);
            idle(1);
            cmp_raw <= 3'b000;
            idle(8);
            n  = int'(f1) + ((clr || !f1) ? int'(f2) : 0);
            ev = (clr || !f1) ? f2 : 1'b1;
            chk(16'(trig_cnt - base), 16'(n));
            @(negedge core_clk);
            chk(16'(irq), 16'(n != 0));
            rchk(OFS_CON_BASE, cfg | {6'h0, ev, inv, 8'h0});
            wr(OFS_CON_BASE, 16'h0000);
        end
        wr(OFS_IRQ_MASK, 16'h0000);
        idle(2);
        @(negedge core_clk);
        chk(16'(irq), 16'h0000);
        rchk(OFS_IRQ_STAT, 16'h0001);
        wr(OFS_IRQ_MASK, 16'h0007);
        idle(2);
        @(negedge core_clk);
        chk(16'(irq), 16'h0001);
        wr(OFS_IRQ_STAT, 16'h0001);
        idle(2);
        @(negedge core_clk);
        chk(16'(irq), 16'h0000);
        $display("test events done");
        for (int i = 0; i < 3; i++)
            wr(OFS_CON_BASE + 8'(4 * i), 16'h80c0);
        wr(OFS_STATUS, 16'hffff);
        rchk(OFS_STATUS, 16'h8000);
        idle(1);
        idle_mode <= 1'b1;
        idle(2);
        base = trig_cnt;
        repeat (20)
        begin
            @(posedge core_clk);
            cmp_raw <= 3'($urandom);
            idle(3);
            @(negedge core_clk);
            chk(16'(unit_power_on), 16'h0000);
        end
        chk(16'(trig_cnt - base), 16'h0000);
        wr(OFS_STATUS, 16'h0000);
        idle(3);
        @(negedge core_clk);
        chk(16'(unit_power_on), 16'h0007);
        // Halt bit clear: units keep firing while idle
        base = trig_cnt;
        idle(1);
        cmp_raw <= ~cmp_raw;
        idle(8);
        chk(16'(trig_cnt - base), 16'h0003);
        $display("test idle done");
        print_verdict;
    end
endmodule // cmpev_top_tb
`default_nettype wire
